//--- sib_regs.svh
`ifndef SIB_REGS_SVH
`define SIB_REGS_SVH
// How it works
// - write: address, index, count each acknowledged
// - data bytes stored from index upward, each acked
// - host closes a block write with stop
// - read: address write, index, both acknowledged
// - repeated start, read address is acknowledged
// - device sends byte count first
// - then registers from index, increasing order
// - host acks every read byte but last
// - host nacks last byte, then stop
// - nine slave addresses from two tri-level straps
// - reg0 bits 7:6,0 read latched straps
// - nineteen enable bits, reset one, force pairs low
// - reg3, reg4, reg0 bits 2:1 read zero
// - count register, default 8, limits read length

// timing
`define SIB_CLK_PERIOD_NS 10
`define SIB_SCL_PHASE_NS  3500
`define SIB_SCL_PHASE_CYC (`SIB_SCL_PHASE_NS / `SIB_CLK_PERIOD_NS)

// slave addresses, write direction, {high strap, low strap}
`define SIB_ADDR_00 8'hD8
`define SIB_ADDR_0M 8'hDA
`define SIB_ADDR_01 8'hDE
`define SIB_ADDR_M0 8'hC2
`define SIB_ADDR_MM 8'hC4
`define SIB_ADDR_M1 8'hC6
`define SIB_ADDR_10 8'hCA
`define SIB_ADDR_1M 8'hCC
`define SIB_ADDR_11 8'hCE

// device register indices and reset values
`define SIB_IDX_LOOP   8'h00
`define SIB_IDX_ENLO   8'h01
`define SIB_IDX_ENMID  8'h02
`define SIB_IDX_RSV3   8'h03
`define SIB_IDX_RSV4   8'h04
`define SIB_IDX_COUNT  8'h07
`define SIB_EN_RST     19'h7FFFF
`define SIB_COUNT_RST  5'h08

// host command port map
`define SIB_H_CTRL  5'h00
`define SIB_H_SLAVE 5'h01
`define SIB_H_INDEX 5'h02
`define SIB_H_COUNT 5'h03
`define SIB_H_RXCNT 5'h04
`define SIB_H_BUF   2'h1
`define SIB_H_DEPTH 4'h8
`endif

//--- sib_pkg.sv
package sib_pkg;
  // strap pin level
  typedef enum logic [1:0] {SIB_LVL_LOW, SIB_LVL_MID, SIB_LVL_HIGH} sib_lvl_t;
  // device protocol states
  typedef enum logic [2:0] {DS_IDLE, DS_RX, DS_RXACK, DS_TX, DS_TXACK} sib_dst_t;
  // host sequencer states
  typedef enum logic [3:0] {HS_IDLE, HS_START1, HS_START2, HS_LO, HS_HI, HS_SMP,
                            HS_RS1, HS_RS2, HS_STOP1, HS_STOP2, HS_STOP3} sib_hst_t;
endpackage

//--- sib_if.sv
`timescale 1ns/1ns
interface sib_if;
  logic hostSclOut;  // host clock drive value
  logic hostSclOe;   // host pulls clock
  logic hostSdaOut;  // host data drive value
  logic hostSdaOe;   // host pulls data
  logic devSdaOut;   // device data drive value
  logic devSdaOe;    // device pulls data
  logic scl;         // resolved bus clock
  logic sda;         // resolved bus data
  // open-drain wire with pull-up
  assign scl = !(hostSclOe && !hostSclOut);
  assign sda = !((hostSdaOe && !hostSdaOut) || (devSdaOe && !devSdaOut));
  modport host (output hostSclOut, hostSclOe, hostSdaOut, hostSdaOe, input scl, sda);
  modport dev  (output devSdaOut, devSdaOe, input scl, sda);
endinterface

//--- sib_device.sv
// Added by the designer: the plain strobed port.
`timescale 1ns/1ns
`include "sib_regs.svh"
module sib_device
  import sib_pkg::*;
(
  input  wire logic     clk_sys,
  input  wire logic     srst,
  sib_if.dev            bus,
  input  wire sib_lvl_t addrStrapHigh,
  input  wire sib_lvl_t addrStrapLow,
  input  wire logic [1:0] loopModeStrap,
  input  wire logic     freqStrap,
  output logic [18:0]   pairEnable
);
  ////////////////////////////////////////////////////////////////
  logic [2:0]  sclSync_q;     // clock pin sampler
  logic [2:0]  sdaSync_q;     // data pin sampler
  logic        sclF_q;        // filtered clock
  logic        sdaF_q;        // filtered data
  logic        sclP_q;        // previous filtered clock
  logic        sdaP_q;        // previous filtered data
  logic [7:0]  strapS1_q;     // strap sampler stages, top bit marks a filled stage
  logic [7:0]  strapS2_q;     // so the cleared stages after reset never count as straps
  logic [7:0]  strapS3_q;
  logic        latched_q;     // straps captured
  logic [7:0]  myAddr_q;      // decoded slave address
  logic [1:0]  loopMode_q;    // latched loop mode
  logic        freqSel_q;     // latched frequency strap
  sib_dst_t    st_q;          // protocol state
  logic [3:0]  bitCnt_q;      // bit within byte
  logic [7:0]  shift_q;       // byte shifter
  logic [1:0]  byteNum_q;     // 0 addr, 1 index, 2 count, 3 data
  logic        isRead_q;      // read address seen
  logic        ackIt_q;       // acknowledge pending byte
  logic [7:0]  idx_q;         // register pointer
  logic [7:0]  left_q;        // write bytes still to store
  logic [5:0]  txLeft_q;      // read bytes still allowed
  logic        sdaOe_q;       // data pull
  logic        wrEn_q;        // register write pulse
  logic [7:0]  wrIdx_q;       // register write index
  logic [7:0]  wrData_q;      // register write data
  logic [18:0] en_q;          // output enable bits
  logic [4:0]  count_q;       // read length register
  logic        sclRise;
  logic        sclFall;
  logic        startSeen;
  logic        stopSeen;
  logic [7:0]  rxByte;
  logic [7:0]  rdByte;

  ////////////////////////////////////////////////////////////////
  // edge and condition decode on the filtered pins
  assign sclRise   = sclF_q && !sclP_q;
  assign sclFall   = !sclF_q && sclP_q;
  assign startSeen = sclF_q && sclP_q && !sdaF_q && sdaP_q;
  assign stopSeen  = sclF_q && sclP_q && sdaF_q && !sdaP_q;
  assign rxByte    = {shift_q[6:0], sdaF_q};
  assign bus.devSdaOe  = sdaOe_q;
  assign bus.devSdaOut = 1'b0;
  assign pairEnable    = en_q;

  // register read view
  always_comb begin
    rdByte = 8'h00;
    unique case (idx_q)
      `SIB_IDX_LOOP:  rdByte = {loopMode_q, en_q[18:16], 2'b00, freqSel_q};
      `SIB_IDX_ENLO:  rdByte = en_q[7:0];
      `SIB_IDX_ENMID: rdByte = en_q[15:8];
      `SIB_IDX_COUNT: rdByte = {3'b000, count_q};
      default:        rdByte = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////
  // pin samplers; a change counts once stages two and three agree
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sclSync_q <= 3'h7;
      sdaSync_q <= 3'h7;
      sclF_q    <= 1'b1;
      sdaF_q    <= 1'b1;
      sclP_q    <= 1'b1;
      sdaP_q    <= 1'b1;
    end else begin
      sclSync_q <= {sclSync_q[1:0], bus.scl};
      sdaSync_q <= {sdaSync_q[1:0], bus.sda};
      if (sclSync_q[1] == sclSync_q[2]) begin
        sclF_q <= sclSync_q[2];
      end
      if (sdaSync_q[1] == sdaSync_q[2]) begin
        sdaF_q <= sdaSync_q[2];
      end
      sclP_q <= sclF_q;
      sdaP_q <= sdaF_q;
    end
  end

  ////////////////////////////////////////////////////////////////
  // straps caught once after reset release, never during it
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      strapS1_q  <= 8'h00;
      strapS2_q  <= 8'h00;
      strapS3_q  <= 8'h00;
      latched_q  <= 1'b0;
      myAddr_q   <= 8'h00;
      loopMode_q <= 2'b00;
      freqSel_q  <= 1'b0;
    end else begin
      strapS1_q <= {1'b1, addrStrapHigh, addrStrapLow, loopModeStrap, freqStrap};
      strapS2_q <= strapS1_q;
      strapS3_q <= strapS2_q;
      if (!latched_q && strapS3_q[7] && strapS2_q == strapS3_q) begin
        latched_q  <= 1'b1;
        loopMode_q <= strapS3_q[2:1];
        freqSel_q  <= strapS3_q[0];
        unique case (strapS3_q[6:5])
          SIB_LVL_LOW: myAddr_q <= (strapS3_q[4:3] == SIB_LVL_LOW) ? `SIB_ADDR_00 :
                                   (strapS3_q[4:3] == SIB_LVL_MID) ? `SIB_ADDR_0M : `SIB_ADDR_01;
          SIB_LVL_MID: myAddr_q <= (strapS3_q[4:3] == SIB_LVL_LOW) ? `SIB_ADDR_M0 :
                                   (strapS3_q[4:3] == SIB_LVL_MID) ? `SIB_ADDR_MM : `SIB_ADDR_M1;
          default:     myAddr_q <= (strapS3_q[4:3] == SIB_LVL_LOW) ? `SIB_ADDR_10 :
                                   (strapS3_q[4:3] == SIB_LVL_MID) ? `SIB_ADDR_1M : `SIB_ADDR_11;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // bus protocol; start and stop override any byte in flight
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st_q      <= DS_IDLE;
      bitCnt_q  <= 4'h0;
      shift_q   <= 8'h00;
      byteNum_q <= 2'h0;
      isRead_q  <= 1'b0;
      ackIt_q   <= 1'b0;
      idx_q     <= 8'h00;
      left_q    <= 8'h00;
      txLeft_q  <= 6'h00;
      sdaOe_q   <= 1'b0;
      wrEn_q    <= 1'b0;
      wrIdx_q   <= 8'h00;
      wrData_q  <= 8'h00;
    end else begin
      wrEn_q <= 1'b0;
      if (startSeen) begin
        // repeated start keeps the pointer for the read phase
        st_q      <= DS_RX;
        bitCnt_q  <= 4'h0;
        byteNum_q <= 2'h0;
        sdaOe_q   <= 1'b0;
      end else if (stopSeen) begin
        st_q    <= DS_IDLE;
        sdaOe_q <= 1'b0;
      end else begin
        unique case (st_q)
          DS_IDLE: begin
          end
          DS_RX: begin
            if (sclRise && bitCnt_q < 4'h8) begin
              shift_q  <= rxByte;
              bitCnt_q <= bitCnt_q + 4'h1;
              if (bitCnt_q == 4'h7) begin
                unique case (byteNum_q)
                  2'h0: begin
                    ackIt_q  <= latched_q && (rxByte[7:1] == myAddr_q[7:1]);
                    isRead_q <= rxByte[0];
                  end
                  2'h1: begin
                    idx_q   <= rxByte;
                    ackIt_q <= 1'b1;
                  end
                  2'h2: begin
                    left_q  <= rxByte;
                    ackIt_q <= 1'b1;
                  end
                  default: begin
                    ackIt_q <= 1'b1;
                    if (left_q != 8'h00) begin
                      // bytes past the count are acked and dropped
                      wrEn_q   <= 1'b1;
                      wrIdx_q  <= idx_q;
                      wrData_q <= rxByte;
                      idx_q    <= idx_q + 8'h01;
                      left_q   <= left_q - 8'h01;
                    end
                  end
                endcase
              end
            end else if (sclFall && bitCnt_q == 4'h8) begin
              if (ackIt_q) begin
                st_q    <= DS_RXACK;
                sdaOe_q <= 1'b1;
              end else begin
                st_q <= DS_IDLE; // not ours: stay silent until next start
              end
            end
          end
          DS_RXACK: begin
            if (sclFall) begin
              bitCnt_q <= 4'h0;
              if (byteNum_q == 2'h0 && isRead_q) begin
                st_q     <= DS_TX;
                shift_q  <= {3'b000, count_q};
                sdaOe_q  <= 1'b1;                // count msb is always zero
                txLeft_q <= {1'b0, count_q} + 6'h01;
              end else begin
                st_q      <= DS_RX;
                sdaOe_q   <= 1'b0;
                byteNum_q <= (byteNum_q == 2'h3) ? 2'h3 : byteNum_q + 2'h1;
              end
            end
          end
          DS_TX: begin
            if (sclFall) begin
              bitCnt_q <= bitCnt_q + 4'h1;
              shift_q  <= {shift_q[6:0], 1'b0};
              if (bitCnt_q == 4'h7) begin
                st_q    <= DS_TXACK;
                sdaOe_q <= 1'b0;
              end else begin
                sdaOe_q <= !shift_q[6];
              end
            end
          end
          DS_TXACK: begin
            if (sclRise && sdaF_q) begin
              st_q <= DS_IDLE; // host nack ends the read
            end else if (sclFall) begin
              st_q     <= DS_TX;
              bitCnt_q <= 4'h0;
              if (txLeft_q != 6'h00) begin
                shift_q  <= rdByte;
                sdaOe_q  <= !rdByte[7];
                idx_q    <= idx_q + 8'h01;
                txLeft_q <= txLeft_q - 6'h01;
              end else begin
                shift_q <= 8'hFF;
                sdaOe_q <= 1'b0;
              end
            end
          end
          default: st_q <= DS_IDLE;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // register bank; read-only and reserved bits ignore writes
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      en_q    <= `SIB_EN_RST;
      count_q <= `SIB_COUNT_RST;
    end else if (wrEn_q) begin
      unique case (wrIdx_q)
        `SIB_IDX_LOOP:  en_q[18:16] <= wrData_q[5:3];
        `SIB_IDX_ENLO:  en_q[7:0]   <= wrData_q;
        `SIB_IDX_ENMID: en_q[15:8]  <= wrData_q;
        `SIB_IDX_COUNT: count_q     <= wrData_q[4:0];
        default: begin
        end
      endcase
    end
  end
endmodule

//--- sib_host.sv
`timescale 1ns/1ns
`include "sib_regs.svh"
module sib_host
  import sib_pkg::*;
#(
  parameter int PHASE_CYC = `SIB_SCL_PHASE_CYC
)(
  input  wire logic       clk_sys,
  input  wire logic       srst,
  sib_if.host             bus,
  input  wire logic [4:0] cmdAddr,
  input  wire logic [7:0] cmdWdata,
  input  wire logic       cmdWr,
  input  wire logic       cmdRd,
  output logic [7:0]      cmdRdata
);
  ////////////////////////////////////////////////////////////////
  logic [15:0] div_q;        // phase divider
  logic [2:0]  sdaSync_q;    // data pin sampler
  logic        sdaF_q;       // filtered data
  sib_hst_t    st_q;         // sequencer state
  logic [3:0]  step_q;       // byte step in transaction
  logic [3:0]  bit_q;        // bit within byte, 8 is ack
  logic [7:0]  rxShift_q;    // received byte
  logic        sclOe_q;
  logic        sdaOe_q;
  logic        busy_q;
  logic        done_q;
  logic        nack_q;       // device refused a byte
  logic        readMode_q;
  logic [7:0]  slave_q;
  logic [7:0]  index_q;
  logic [3:0]  count_q;
  logic [7:0]  rxCnt_q;      // count byte returned by device
  logic [7:0]  buf_q [8];    // data bytes both ways
  logic [7:0]  cmdRdata_q;
  logic        tick;
  logic        rxing;
  logic        lastRx;
  logic [7:0]  curTx;
  logic [3:0]  bufOff;

  assign tick    = (div_q == 16'(PHASE_CYC - 1));
  assign rxing   = readMode_q && step_q >= 4'h3;
  assign lastRx  = step_q == 4'h3 + count_q;
  assign bufOff  = step_q - (readMode_q ? 4'h4 : 4'h3);
  assign bus.hostSclOe  = sclOe_q;
  assign bus.hostSdaOe  = sdaOe_q;
  assign bus.hostSclOut = 1'b0;
  assign bus.hostSdaOut = 1'b0;
  assign cmdRdata       = cmdRdata_q;

  // byte to send at this step
  always_comb begin
    curTx = buf_q[bufOff[2:0]];
    unique case (step_q)
      4'h0:    curTx = {slave_q[7:1], 1'b0};
      4'h1:    curTx = index_q;
      4'h2:    curTx = readMode_q ? {slave_q[7:1], 1'b1} : {4'h0, count_q};
      default: curTx = buf_q[bufOff[2:0]];
    endcase
  end

  ////////////////////////////////////////////////////////////////
  // phase divider and data sampler; a slow bus trades speed for margin
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      div_q     <= 16'h0000;
      sdaSync_q <= 3'h7;
      sdaF_q    <= 1'b1;
    end else begin
      div_q     <= tick ? 16'h0000 : div_q + 16'h0001;
      sdaSync_q <= {sdaSync_q[1:0], bus.sda};
      if (sdaSync_q[1] == sdaSync_q[2]) begin
        sdaF_q <= sdaSync_q[2];
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // setup registers, written only while idle
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      slave_q <= `SIB_ADDR_00;
      index_q <= 8'h00;
      count_q <= 4'h0;
    end else if (cmdWr && !busy_q) begin
      if (cmdAddr == `SIB_H_SLAVE) slave_q <= cmdWdata;
      if (cmdAddr == `SIB_H_INDEX) index_q <= cmdWdata;
      if (cmdAddr == `SIB_H_COUNT) count_q <= (cmdWdata[3:0] > `SIB_H_DEPTH) ? `SIB_H_DEPTH : cmdWdata[3:0];
    end
  end

  // command read data, one cycle after the strobe
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cmdRdata_q <= 8'h00;
    end else if (cmdRd) begin
      unique case (cmdAddr)
        `SIB_H_CTRL:  cmdRdata_q <= {5'h00, done_q, nack_q, busy_q};
        `SIB_H_SLAVE: cmdRdata_q <= slave_q;
        `SIB_H_INDEX: cmdRdata_q <= index_q;
        `SIB_H_COUNT: cmdRdata_q <= {4'h0, count_q};
        `SIB_H_RXCNT: cmdRdata_q <= rxCnt_q;
        default:      cmdRdata_q <= (cmdAddr[4:3] == `SIB_H_BUF) ? buf_q[cmdAddr[2:0]] : 8'h00;
      endcase
    end else begin
      cmdRdata_q <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////
  // bus sequencer; each state but idle lasts one phase
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st_q       <= HS_IDLE;
      step_q     <= 4'h0;
      bit_q      <= 4'h0;
      rxShift_q  <= 8'h00;
      sclOe_q    <= 1'b0;
      sdaOe_q    <= 1'b0;
      busy_q     <= 1'b0;
      done_q     <= 1'b0;
      nack_q     <= 1'b0;
      readMode_q <= 1'b0;
      rxCnt_q    <= 8'h00;
      for (int i = 0; i < 8; i++) buf_q[i] <= 8'h00;
    end else begin
      if (cmdWr && !busy_q && cmdAddr[4:3] == `SIB_H_BUF) buf_q[cmdAddr[2:0]] <= cmdWdata;
      if (st_q == HS_IDLE) begin
        if (cmdWr && cmdAddr == `SIB_H_CTRL && cmdWdata[0]) begin
          busy_q     <= 1'b1;
          done_q     <= 1'b0;
          nack_q     <= 1'b0;
          readMode_q <= cmdWdata[1];
          step_q     <= 4'h0;
          st_q       <= HS_START1;
        end
      end else if (tick) begin
        unique case (st_q)
          HS_START1: begin
            sdaOe_q <= 1'b1; // data falls while clock high
            st_q    <= HS_START2;
          end
          HS_START2: begin
            sclOe_q <= 1'b1;
            bit_q   <= 4'h0;
            st_q    <= HS_LO;
          end
          HS_LO: begin
            if (bit_q == 4'h8) sdaOe_q <= rxing && !lastRx;
            else sdaOe_q <= !rxing && !curTx[3'h7 - bit_q[2:0]];
            st_q <= HS_HI;
          end
          HS_HI: begin
            sclOe_q <= 1'b0;
            st_q    <= HS_SMP;
          end
          HS_SMP: begin
            sclOe_q <= 1'b1;
            st_q    <= HS_LO;
            if (bit_q != 4'h8) begin
              rxShift_q <= {rxShift_q[6:0], sdaF_q};
              bit_q     <= bit_q + 4'h1;
            end else begin
              bit_q <= 4'h0;
              if (rxing) begin
                if (step_q == 4'h3) rxCnt_q <= rxShift_q;
                else buf_q[bufOff[2:0]] <= rxShift_q;
                if (lastRx) st_q <= HS_STOP1;
                step_q <= step_q + 4'h1;
              end else if (sdaF_q) begin
                nack_q <= 1'b1;
                st_q   <= HS_STOP1;
              end else if (!readMode_q && step_q == 4'h2 + count_q) begin
                st_q <= HS_STOP1;
              end else if (readMode_q && step_q == 4'h1) begin
                step_q <= 4'h2;
                st_q   <= HS_RS1;
              end else begin
                step_q <= step_q + 4'h1;
              end
            end
          end
          HS_RS1: begin
            sdaOe_q <= 1'b0;
            st_q    <= HS_RS2;
          end
          HS_RS2: begin
            sclOe_q <= 1'b0;
            st_q    <= HS_START1;
          end
          HS_STOP1: begin
            sdaOe_q <= 1'b1;
            st_q    <= HS_STOP2;
          end
          HS_STOP2: begin
            sclOe_q <= 1'b0;
            st_q    <= HS_STOP3;
          end
          HS_STOP3: begin
            sdaOe_q <= 1'b0; // data rises while clock high
            busy_q  <= 1'b0;
            done_q  <= 1'b1;
            st_q    <= HS_IDLE;
          end
          default: st_q <= HS_IDLE;
        endcase
      end
    end
  end
endmodule

//--- sib_checker.sv
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////
// wire-level checks on the shared bus, both ends are design code
module sib_checker (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic hostSclOe,
  input wire logic hostSdaOe,
  input wire logic devSdaOe,
  input wire logic scl,
  input wire logic sda
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  ////////////////////////////////////////////////////////////////////////
  // idle after reset, nobody pulls a line
  a_reset_idle: assert property ($fell(srst) |-> !hostSclOe && !hostSdaOe && !devSdaOe)
    else $error("bus not idle after reset");
  // device moves its data line only while the clock is low
  a_dev_scl_low: assert property ($changed(devSdaOe) |-> !scl)
    else $error("device changed data while clock high");
  // a driven device bit stands at least eight cycles past its rise
  a_dev_bit_hold: assert property ($rose(devSdaOe) |=> devSdaOe[*8])
    else $error("device bit too short");
  // clock phases never shorter than the filter can follow
  a_scl_low_min: assert property ($fell(scl) |-> !scl[*8])
    else $error("clock low phase too short");
  a_scl_high_min: assert property ($rose(scl) |-> scl[*8])
    else $error("clock high phase too short");
  // only the host may frame a start
  a_start_by_host: assert property ($fell(sda) && scl |-> hostSdaOe)
    else $error("start not made by host");
  // data stable while clock high, except host start or stop
  a_sda_framed: assert property (scl && $past(scl) && $changed(sda) |-> $changed(hostSdaOe))
    else $error("data moved while clock high");
  // after a stop the host leaves the clock released
  a_stop_idle: assert property ($rose(sda) && scl |=> !hostSclOe[*8])
    else $error("clock pulled right after stop");
endmodule

//--- smbus_index_block_slave_regs_tb.sv
`timescale 1ns/1ns
`include "sib_regs.svh"
module smbus_index_block_slave_regs_tb
  import sib_pkg::*;
;
  logic        clk_sys, srst, cmdWr, cmdRd, freqStrap;
  logic [4:0]  cmdAddr;
  logic [7:0]  cmdWdata, cmdRdata, rv;
  logic [1:0]  loopModeStrap;
  logic [18:0] pairEnable;
  sib_lvl_t    addrStrapHigh, addrStrapLow;
  int          fails, comparisons;
  // address per strap pair, index = high*3 + low
  logic [7:0]  addrTab [9] = '{`SIB_ADDR_00, `SIB_ADDR_0M, `SIB_ADDR_01, `SIB_ADDR_M0, `SIB_ADDR_MM,
                                `SIB_ADDR_M1, `SIB_ADDR_10, `SIB_ADDR_1M, `SIB_ADDR_11};
  sib_if bus_i ();
  sib_device sib_device_i (.clk_sys(clk_sys), .srst(srst), .bus(bus_i.dev), .addrStrapHigh(addrStrapHigh),
    .addrStrapLow(addrStrapLow), .loopModeStrap(loopModeStrap), .freqStrap(freqStrap), .pairEnable(pairEnable));
  // short phase keeps the run small, still well above the filter delay
  sib_host #(.PHASE_CYC(20)) sib_host_i (.clk_sys(clk_sys), .srst(srst), .bus(bus_i.host), .cmdAddr(cmdAddr),
    .cmdWdata(cmdWdata), .cmdWr(cmdWr), .cmdRd(cmdRd), .cmdRdata(cmdRdata));
  sib_checker sib_checker_i (.clk_sys(clk_sys), .srst(srst), .hostSclOe(bus_i.hostSclOe),
    .hostSdaOe(bus_i.hostSdaOe), .devSdaOe(bus_i.devSdaOe), .scl(bus_i.scl), .sda(bus_i.sda));
  ////////////////////////////////////////////////////////////////////////
  // shared tasks
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    cmdWr <= 1'b1;
    cmdAddr <= a;
    cmdWdata <= d;
    @(posedge clk_sys);
    cmdWr <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    cmdRd <= 1'b1;
    cmdAddr <= a;
    @(posedge clk_sys);
    cmdRd <= 1'b0;
    #1 d = cmdRdata;
  endtask
  // one whole bus transaction, polled to completion under a bound
  task automatic xfer(input logic [7:0] sa, input logic [7:0] n, input logic [7:0] x, input logic isRd);
    int k;
    k = 0;
    wr(`SIB_H_SLAVE, sa);
    wr(`SIB_H_INDEX, n);
    wr(`SIB_H_COUNT, x);
    wr(`SIB_H_CTRL, {6'h00, isRd, 1'b1});
    do begin
      repeat (20) @(posedge clk_sys);
      rd(`SIB_H_CTRL, rv);
      k++;
    end while (rv[2] !== 1'b1 && k < 2000);
    chk("done flag", 1, rv[2]);
  endtask
  task automatic do_reset(input int s);
    @(posedge clk_sys);
    addrStrapHigh <= sib_lvl_t'(2'(s / 3));
    addrStrapLow <= sib_lvl_t'(2'(s % 3));
    srst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
    repeat (12) @(posedge clk_sys);
  endtask
  // block read of x bytes from n, count byte then data bytes
  task automatic rdchk(input logic [7:0] n, input logic [3:0] x, input logic [7:0] c, input logic [63:0] e);
    xfer(addrTab[8], n, 8'(x), 1'b1);
    chk("read nack", 0, rv[1]);
    rd(`SIB_H_RXCNT, rv);
    chk("count byte", c, rv);
    for (int i = 0; i < x; i++) begin
      rd({`SIB_H_BUF, 3'(i)}, rv);
      chk("read byte", e[8*i +: 8], rv);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_addresses();
    for (int s = 0; s < 9; s++) begin
      do_reset(s);
      xfer(addrTab[s], 8'h03, 8'h00, 1'b0);
      chk("own address ack", 0, rv[1]);
      xfer(addrTab[s] ^ 8'h02, 8'h03, 8'h00, 1'b0);
      chk("foreign address nack", 1, rv[1]);
    end
  endtask
  task automatic t_defaults();
    chk("enables at reset", 19'h7FFFF, pairEnable);
    rdchk(8'h00, 4'h5, 8'h08, {24'h0, 16'h0000, 16'hFFFF, loopModeStrap, 6'b111001});
  endtask
  // read-only and reserved bits are written with ones and must not stick
  task automatic t_write();
    wr({`SIB_H_BUF, 3'h0}, 8'hC7);
    wr({`SIB_H_BUF, 3'h1}, 8'h5A);
    wr({`SIB_H_BUF, 3'h2}, 8'h3C);
    wr({`SIB_H_BUF, 3'h3}, 8'hFF);
    wr({`SIB_H_BUF, 3'h4}, 8'hFF);
    xfer(addrTab[8], 8'h00, 8'h05, 1'b0);
    chk("write acked", 0, rv[1]);
    chk("enables after write", {3'b000, 16'h3C5A}, pairEnable);
    rdchk(8'h00, 4'h5, 8'h08, {24'h0, 16'h0000, 16'h3C5A, loopModeStrap, 6'b000001});
  endtask
  // shorter count register, bytes past count plus one read as released bus
  task automatic t_count();
    wr({`SIB_H_BUF, 3'h0}, 8'h03);
    xfer(addrTab[8], `SIB_IDX_COUNT, 8'h01, 1'b0);
    rdchk(8'h01, 4'h6, 8'h03, {16'h0, 16'hFFFF, 16'h0000, 16'h3C5A});
    rdchk(`SIB_IDX_COUNT, 4'h1, 8'h03, {56'h0, 8'h03});
  endtask
  // other strap levels, caught at the next reset
  task automatic t_straps();
    @(posedge clk_sys);
    loopModeStrap <= 2'b01;
    freqStrap <= 1'b0;
    do_reset(8);
    rdchk(8'h00, 4'h1, 8'h08, {56'h0, 8'h78});
  endtask
  task automatic print_verdict();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // hang guard, well beyond the expected run length
  initial begin
    #900000;
    fails++;
    print_verdict();
  end
  initial begin
    srst = 1'b1;
    cmdWr = 1'b0;
    cmdRd = 1'b0;
    cmdAddr = 5'h00;
    cmdWdata = 8'h00;
    loopModeStrap = 2'b10;
    freqStrap = 1'b1;
    addrStrapHigh = SIB_LVL_LOW;
    addrStrapLow = SIB_LVL_LOW;
    fails = 0;
    comparisons = 0;
    t_addresses();
    t_defaults();
    t_write();
    t_count();
    t_straps();
    print_verdict();
  end
endmodule
